// ### logic/rx_multi_pin_mux.sv
// Selector for one port's three receive multifunction pins
// Summary of operation
// - Each pin's function comes from its own 4-bit select field.
// - After reset every pin is an input and is not driven.
// - Pin direction follows the selected function automatically.
// - Edge select bit picks rising or falling framer clock edge for data.
// - An unconnected pin reads as logic high.
// - Select code all ones drives the receive clock out.
module rx_multi_pin_mux
    import rx_pin_mux_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire pin_function_config_regs_type rx_pin_function_select,
    input wire logic rx_edge_select,
    input wire logic framer_rx_interface_clock,
    input wire pin_source_type src,
    input wire logic [2:0] pin_in,
    input wire logic [2:0] pin_connected,
    output pin_sink_type sink,
    output logic [2:0] pin_out,
    output logic [2:0] pin_oe_n
);

    typedef struct packed {
        logic fclk_r;
        logic [2:0] out_r;
        logic [2:0] oe_n_r;
        pin_sink_type sink_r;
    } state_type;

    localparam state_type STATE_RESET = '{
        fclk_r: FCLK_RESET,
        out_r: OUT_RESET,
        oe_n_r: OE_N_RESET,
        sink_r: SINK_RESET
    };

    state_type st_r;
    state_type st_nxt;

    // Picks one pin's 4-bit code out of the port's selector word
    function automatic logic [3:0] pin_code(input pin_function_config_regs_type cfg,
            input int idx);
        logic [3:0] code;
        code = FUNC_RESET;
        unique case (idx)
            PIN_A: begin
                code = cfg.sel_a;
            end
            PIN_B: begin
                code = cfg.sel_b;
            end
            PIN_C: begin
                code = cfg.sel_c;
            end
            default: begin
                code = FUNC_RESET;
            end
        endcase
        pin_code = code;
    endfunction : pin_code

    // Codes that turn a pin into an output
    function automatic logic is_output(input logic [3:0] code);
        logic result;
        result = 1'b0;
        unique case (code)
            FUNC_RX_CLOCK: begin
                result = 1'b1;
            end
            FUNC_OUT_SYNC: begin
                result = 1'b1;
            end
            FUNC_OUT_VIOL: begin
                result = 1'b1;
            end
            FUNC_OUT_LOS: begin
                result = 1'b1;
            end
            default: begin
                // Every other code, known or not, leaves the pin an input
                result = 1'b0;
            end
        endcase
        is_output = result;
    endfunction : is_output

    // Value an output function puts on its pin at a framer clock edge
    function automatic logic out_value(input logic [3:0] code, input pin_source_type s);
        logic result;
        result = PULL_UP_LEVEL;
        unique case (code)
            FUNC_RX_CLOCK: begin
                result = s.rx_clock;
            end
            FUNC_OUT_SYNC: begin
                result = s.sync_out;
            end
            FUNC_OUT_VIOL: begin
                result = s.viol_out;
            end
            FUNC_OUT_LOS: begin
                result = s.los_out;
            end
            default: begin
                result = PULL_UP_LEVEL;
            end
        endcase
        out_value = result;
    endfunction : out_value

    // Next value of one output flop
    function automatic logic out_next(input logic [3:0] code, input pin_source_type s,
            input logic hit, input logic old);
        logic result;
        result = old;
        if (code == FUNC_RX_CLOCK) begin
            // Receive clock bypasses edge sampling, else it would be halved
            result = s.rx_clock;
        end else if (hit) begin
            result = out_value(code, s);
        end
        out_next = result;
    endfunction : out_next

    // Level the logic sees on a pin
    function automatic logic read_level(input logic level, input logic connected);
        logic result;
        if (connected) begin
            result = level;
        end else begin
            // Pull-up holds a floating pin high
            result = PULL_UP_LEVEL;
        end
        read_level = result;
    endfunction : read_level

    // One framer clock edge of the chosen direction between two samples
    function automatic logic detect_edge(input logic falling, input logic now,
            input logic last);
        logic hit;
        if (falling == EDGE_RISING) begin
            hit = now && !last;
        end else begin
            hit = !now && last;
        end
        detect_edge = hit;
    endfunction : detect_edge

    // Folds one pin into the input sinks; later pins win
    function automatic pin_sink_type sink_update(input pin_sink_type old,
            input logic [3:0] code, input logic level);
        pin_sink_type result;
        result = old;
        unique case (code)
            FUNC_IN_DATA: begin
                result.data_in = level;
            end
            FUNC_IN_SYNC: begin
                result.sync_in = level;
            end
            default: begin
                result = old;
            end
        endcase
        sink_update = result;
    endfunction : sink_update

    logic [3:0] sel [PIN_COUNT];
    logic [2:0] pin_level;
    logic [2:0] drive;
    logic edge_hit;

    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            sel[i] = pin_code(rx_pin_function_select, i);
            pin_level[i] = read_level(pin_in[i], pin_connected[i]);
            // Direction is derived only from this pin's own code
            drive[i] = is_output(sel[i]);
        end
    end

    // Framer clock is sampled as a level; it must run below half of clk
    assign edge_hit = detect_edge(rx_edge_select, framer_rx_interface_clock,
        st_r.fclk_r);

    always_comb begin
        st_nxt = st_r;
        st_nxt.fclk_r = framer_rx_interface_clock;
        st_nxt.oe_n_r = ~drive;

        // Output flops follow their pin's function
        for (int i = 0; i < PIN_COUNT; i++) begin
            st_nxt.out_r[i] = out_next(sel[i], src, edge_hit, st_r.out_r[i]);
        end

        if (edge_hit) begin
            // Relies on software giving each input function to one pin only
            st_nxt.sink_r = SINK_RESET;
            for (int i = 0; i < PIN_COUNT; i++) begin
                st_nxt.sink_r = sink_update(st_nxt.sink_r, sel[i], pin_level[i]);
            end
        end
    end

    // Whole state resets at once; pins come up as inputs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= STATE_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from the state flops
    assign sink = st_r.sink_r;
    assign pin_out = st_r.out_r;
    assign pin_oe_n = st_r.oe_n_r;
endmodule : rx_multi_pin_mux

// ### logic/rx_pin_mux_pkg.sv
// Constants and carrier types for the receive multifunction pin selector
package rx_pin_mux_pkg;
    localparam int SEL_W = 4;
    localparam int PIN_COUNT = 3;
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_C = 2;
    localparam logic [3:0] FUNC_RX_CLOCK = 4'hF;
    localparam logic [3:0] FUNC_IN_DATA = 4'h0;
    localparam logic [3:0] FUNC_IN_SYNC = 4'h1;
    localparam logic [3:0] FUNC_OUT_SYNC = 4'h2;
    localparam logic [3:0] FUNC_OUT_VIOL = 4'h3;
    localparam logic [3:0] FUNC_OUT_LOS = 4'h4;
    localparam logic [3:0] FUNC_RESET = 4'h0;
    localparam logic [2:0] OE_N_RESET = 3'h7;
    localparam logic [2:0] OUT_RESET = 3'h7;
    localparam logic EDGE_RISING = 1'b0;
    localparam logic PULL_UP_LEVEL = 1'b1;
    localparam logic FCLK_RESET = 1'b0;

    // One port's three selectors, A in [0]
    typedef struct packed {
        logic [3:0] sel_c;
        logic [3:0] sel_b;
        logic [3:0] sel_a;
    } pin_function_config_regs_type;

    // Internal signals the pins can carry out to the framer
    typedef struct packed {
        logic rx_clock;
        logic sync_out;
        logic viol_out;
        logic los_out;
    } pin_source_type;

    // Functions a pin can feed into the device
    typedef struct packed {
        logic data_in;
        logic sync_in;
    } pin_sink_type;

    // Sinks idle high when no pin feeds them
    localparam pin_sink_type SINK_RESET = '{data_in: 1'b1, sync_in: 1'b1};
endpackage : rx_pin_mux_pkg

// ### verif/framer_model.sv
// Framer clock, free running at clk over eight
module framer_model (
    input wire logic clk,
    output logic fclk
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] div = 3'h0;
    always @(negedge clk) div <= div + 3'h1;
    assign fclk = div[2];
endmodule : framer_model

// ### verif/rx_pin_mux_asserts.sv
// Pin selector checks
module rx_pin_mux_asserts
    import rx_pin_mux_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire pin_function_config_regs_type rx_pin_function_select,
    input wire logic rx_edge_select,
    input wire logic framer_rx_interface_clock,
    input wire pin_source_type src,
    input wire logic [2:0] pin_connected,
    input wire pin_sink_type sink,
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    reset_idle_a: assert property ($rose(arst_n) |-> pin_oe_n == OE_N_RESET &&
        pin_out == OUT_RESET && sink == SINK_RESET)
        else $error("pin driven after reset");
    clk_out_a: assert property (rx_pin_function_select.sel_a == FUNC_RX_CLOCK |=>
        !pin_oe_n[0] && pin_out[0] == $past(src.rx_clock))
        else $error("pin A not carrying receive clock");
    dir_follow_a: assert property (rx_pin_function_select.sel_b == FUNC_OUT_SYNC |=>
        !pin_oe_n[1])
        else $error("pin B not driven for output function");
    input_kept_a: assert property (rx_pin_function_select.sel_c == FUNC_IN_DATA |=>
        pin_oe_n[2])
        else $error("pin C driven for input function");
    float_high_a: assert property (rx_edge_select == EDGE_RISING &&
        $rose(framer_rx_interface_clock) && rx_pin_function_select.sel_a == FUNC_IN_DATA &&
        rx_pin_function_select.sel_b != FUNC_IN_DATA &&
        rx_pin_function_select.sel_c != FUNC_IN_DATA && !pin_connected[0] |=> sink.data_in)
        else $error("floating pin not read high");
    edge_pick_a: assert property (rx_edge_select != EDGE_RISING &&
        $rose(framer_rx_interface_clock) |=> $stable(sink))
        else $error("sink changed on unselected edge");
endmodule : rx_pin_mux_asserts

// ### verif/tb.sv
// Pin selector bench
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, arst_n = 1'b0, es = 1'b0, fclk;
    logic [2:0] conn = 3'h7, out, oe_n;
    logic [1:0] sink;
    logic [11:0] sel = 12'h555;
    logic [3:0] src_v = 4'h0;
    int fail_count = 0, num_checks = 0;
    framer_model peer_u (.clk, .fclk);
    rx_multi_pin_mux dut_u (.clk, .arst_n, .rx_pin_function_select(sel), .rx_edge_select(es),
        .framer_rx_interface_clock(fclk), .src(src_v), .pin_in(oe_n & 3'h2 | ~oe_n & out),
        .pin_connected(conn), .sink, .pin_out(out), .pin_oe_n(oe_n));
    initial forever #50 clk = ~clk;
    initial #100000 tally_and_finish(1);
    task automatic check(string s, logic [2:0] seen, want);
        num_checks++;
        fail_count += int'(seen !== want);
        if (seen !== want) $display("mismatch %s expected %h seen %h", s, want, seen);
    endtask : check
    task automatic tally_and_finish(int hung);
        fail_count += hung;
        $display("checks %0d fails %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic t_dir();
        for (int p = 0; p < 3; p++) for (int i = 0; i < 7; i++) begin
            sel[4*p+:4] = i == 5 ? 4'hF : 4'(i);
            repeat (2) @(negedge clk);
            check("oe_n", oe_n, ~(3'(i > 1 && i < 6) << p));
        end
    endtask : t_dir
    task automatic t_in();
        sel = 12'h510; // Unique inputs
        for (int k = 0; k < 4; k++) begin
            {conn, es} = {k[1] ? 3'h6 : 3'h7, k[0]};
            repeat (40) @(negedge clk);
            check("sink", {1'b0, sink}, k[1] ? 3'h3 : 3'h1);
        end
    endtask : t_in
    task automatic t_out();
        sel = 12'h62F; // A clock out, B sync out, C plain input
        src_v = 4'hC;
        repeat (20) @(negedge clk);
        check("pin_out", out & 3'h3, 3'h3);
        src_v = 4'h4;
        repeat (2) @(negedge clk);
        check("pin_out", out & 3'h3, 3'h2);
        src_v = 4'h0;
        repeat (20) @(negedge clk);
        check("pin_out", out & 3'h3, 3'h0);
    endtask : t_out
    task automatic t_rst();
        arst_n = 1'b0;
        @(negedge clk);
        check("oe_n", oe_n, 3'h7);
        check("sink", {1'b0, sink}, 3'h3);
        arst_n = 1'b1;
        @(negedge clk);
        check("oe_n", oe_n, 3'h4);
    endtask : t_rst
    initial begin
        #2000 arst_n = 1'b1;
        check("oe_n", oe_n, 3'h7);
        t_dir();
        t_in();
        t_out();
        t_rst();
        tally_and_finish(0);
    end
endmodule : tb
bind rx_multi_pin_mux rx_pin_mux_asserts chk_u (.clk, .arst_n, .rx_pin_function_select,
    .rx_edge_select, .framer_rx_interface_clock, .src, .pin_connected, .sink, .pin_out,
    .pin_oe_n);
